//--- counter_rear_pkg.sv
`default_nettype none
package counter_rear_pkg;
    // clock and timebase
    localparam int unsigned REF_CLK_HZ     = 10_000_000;
    localparam int unsigned UNIT_NS        = 100;
    localparam int unsigned GATE_TIME_MS   = 1000;
    localparam int unsigned GATE_UNITS_DEF = GATE_TIME_MS * (REF_CLK_HZ / 1000);
    localparam int unsigned RESET_MIN_MS   = 10;
    localparam int unsigned PRESCALE_SHIFT = 4;

    // register map (byte addresses)
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_RESULT = 4'h8;

    // control register fields
    localparam int unsigned CTRL_FUNC_LSB  = 0;
    localparam int unsigned CTRL_EXT_BIT   = 3;
    localparam int unsigned CTRL_FREQ_LSB  = 4;
    localparam int unsigned CTRL_REAR_BIT  = 6;
    localparam int unsigned CTRL_FRONT_BIT = 7;
    localparam logic [7:0]  CTRL_RESET     = 8'hE0;

    // status register fields
    localparam int unsigned STAT_STATE_LSB = 0;
    localparam int unsigned STAT_GATE_BIT  = 3;
    localparam int unsigned STAT_LAMP_BIT  = 4;
    localparam int unsigned STAT_PRE_BIT   = 5;

    // rear pin synchroniser slots
    localparam int unsigned PIN_EXT_REF = 0;
    localparam int unsigned PIN_CH_A    = 1;
    localparam int unsigned PIN_CH_B    = 2;
    localparam int unsigned PIN_PRE_N   = 3;
    localparam int unsigned PIN_RST_N   = 4;
    localparam int unsigned PIN_ARM_N   = 5;
    localparam int unsigned PIN_COUNT   = 6;
    localparam logic [5:0]  PIN_RESET   = 6'h38;

    // external standard weights in 100 ns units
    localparam logic [3:0] WEIGHT_1MHZ  = 4'hA;
    localparam logic [3:0] WEIGHT_5MHZ  = 4'h2;
    localparam logic [3:0] WEIGHT_10MHZ = 4'h1;

    typedef enum logic [1:0] {
        STD_1MHZ  = 2'b00,
        STD_5MHZ  = 2'b01,
        STD_10MHZ = 2'b10
    } std_freq_t;

    typedef enum logic [2:0] {
        frequency_first_channel   = 3'b000,
        period_first_channel      = 3'b001,
        second_over_first_ratio   = 3'b010,
        event_total_first_channel = 3'b011,
        event_total_second        = 3'b100
    } func_t;

    typedef enum logic [2:0] {
        ST_ABORT = 3'b000,
        ST_ARM   = 3'b001,
        ST_SYNC  = 3'b010,
        ST_GATE  = 3'b011,
        ST_DONE  = 3'b100
    } meas_state_t;
endpackage
`default_nettype wire

//--- counter_rear_port_control.sv
`default_nettype none
module counter_rear_port_control
    import counter_rear_pkg::*;
#(
    parameter int unsigned GATE_UNITS = GATE_UNITS_DEF
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic        ext_ref,
    input  wire logic        ch_a,
    input  wire logic        ch_b,
    input  wire logic        prescale_n,
    input  wire logic        rear_reset_n,
    input  wire logic        rear_arm_n,
    output logic             ref_out_q,
    output logic             gate_open_q,
    output logic             lamp_test_q,
    output logic      [31:0] result_q,
    output logic             result_valid_q
);
    wire  [PIN_COUNT-1:0] s2_q;
    wire  [PIN_COUNT-1:0] s3_q;
    logic [7:0]           ctrl_q;
    meas_state_t          state_q;
    meas_state_t          state_d;
    logic [31:0]          count_q;
    logic [31:0]          unit_cnt_q;
    logic [3:0]           unit_inc;
    logic                 arm_ok;
    logic                 a_edge;
    logic                 b_edge;
    logic                 gate_end;
    func_t                func;
    std_freq_t            std_sel;

    function automatic logic [3:0] std_weight(input std_freq_t f);
        case (f)
            STD_1MHZ: std_weight = WEIGHT_1MHZ;
            STD_5MHZ: std_weight = WEIGHT_5MHZ;
            default:  std_weight = WEIGHT_10MHZ;
        endcase
    endfunction

    function automatic logic [31:0] scale(input func_t f, input logic pre, input logic [31:0] v);
        scale = v;
        if (pre) begin
            case (f)
                frequency_first_channel,
                event_total_first_channel: scale = v << PRESCALE_SHIFT;
                period_first_channel,
                second_over_first_ratio:   scale = v >> PRESCALE_SHIFT;
                default:                   scale = v;
            endcase
        end
    endfunction

    // two-flop synchronisers plus an edge stage; reset and arm idle high
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
            logic pin;
            logic m1_q;
            logic m2_q;
            logic m3_q;
            assign pin = (gi == PIN_EXT_REF) ? ext_ref :
                         (gi == PIN_CH_A)    ? ch_a :
                         (gi == PIN_CH_B)    ? ch_b :
                         (gi == PIN_PRE_N)   ? prescale_n :
                         (gi == PIN_RST_N)   ? rear_reset_n : rear_arm_n;
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    m1_q <= PIN_RESET[gi];
                    m2_q <= PIN_RESET[gi];
                    m3_q <= PIN_RESET[gi];
                end else if (ce) begin
                    m1_q <= pin;
                    m2_q <= m1_q;
                    m3_q <= m2_q;
                end
            end
            // each slot owns its flops; only the settled stages leave the block
            assign s2_q[gi] = m2_q;
            assign s3_q[gi] = m3_q;
        end
    endgenerate

    assign func    = func_t'(ctrl_q[CTRL_FUNC_LSB +: 3]);
    assign std_sel = std_freq_t'(ctrl_q[CTRL_FREQ_LSB +: 2]);
    assign a_edge  = s2_q[PIN_CH_A] & ~s3_q[PIN_CH_A];
    assign b_edge  = s2_q[PIN_CH_B] & ~s3_q[PIN_CH_B];

    always_comb begin
        unit_inc = 4'h1;
        if (ctrl_q[CTRL_EXT_BIT]) begin
            unit_inc = (s2_q[PIN_EXT_REF] & ~s3_q[PIN_EXT_REF]) ? std_weight(std_sel) : 4'h0;
        end
    end

    // rear arm gates the front arm
    assign arm_ok = ctrl_q[CTRL_FRONT_BIT] & (~ctrl_q[CTRL_REAR_BIT] | s2_q[PIN_ARM_N]);

    always_comb begin
        case (func)
            frequency_first_channel: gate_end = unit_cnt_q >= GATE_UNITS;
            period_first_channel,
            second_over_first_ratio: gate_end = a_edge;
            default:                 gate_end = ~arm_ok;
        endcase
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_ABORT: state_d = ST_ARM;
            ST_ARM:   if (arm_ok) begin
                state_d = (func == period_first_channel || func == second_over_first_ratio)
                          ? ST_SYNC : ST_GATE;
            end
            ST_SYNC:  if (a_edge) begin
                state_d = ST_GATE;
            end
            ST_GATE:  if (gate_end) begin
                state_d = ST_DONE;
            end
            ST_DONE:  state_d = ST_ARM;
            default:  state_d = ST_ABORT;
        endcase
        if (!s2_q[PIN_RST_N]) begin
            state_d = ST_ABORT;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q     <= ST_ABORT;
            gate_open_q <= 1'b0;
        end else if (ce) begin
            state_q     <= state_d;
            gate_open_q <= (state_d == ST_GATE);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count_q    <= 32'h0000_0000;
            unit_cnt_q <= 32'h0000_0000;
        end else if (ce) begin
            if (state_q != ST_GATE) begin
                count_q    <= 32'h0000_0000;
                unit_cnt_q <= 32'h0000_0000;
            end else begin
                unit_cnt_q <= unit_cnt_q + {28'h0, unit_inc};
                case (func)
                    period_first_channel:    count_q <= count_q + {28'h0, unit_inc};
                    second_over_first_ratio,
                    event_total_second:      count_q <= count_q + {31'h0, b_edge};
                    default:                 count_q <= count_q + {31'h0, a_edge};
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            result_q       <= 32'h0000_0000;
            result_valid_q <= 1'b0;
        end else if (ce) begin
            result_valid_q <= (state_q == ST_DONE);
            if (state_q == ST_DONE) begin
                result_q <= scale(func, ~s2_q[PIN_PRE_N], count_q);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lamp_test_q <= 1'b0;
        end else if (ce) begin
            lamp_test_q <= ~s2_q[PIN_RST_N];
        end
    end

    // timebase clock out, one edge per nonzero unit increment: each 100 ns unit internally, each standard edge when external
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ref_out_q <= 1'b0;
        end else if (ce && unit_inc != 4'h0) begin
            ref_out_q <= ~ref_out_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RESET;
        end else if (ce && wr && addr == OFS_CTRL) begin
            ctrl_q <= wdata[7:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata <= 32'h0000_0000;
        end else if (ce) begin
            rdata <= 32'h0000_0000;
            if (rd) begin
                case (addr)
                    OFS_CTRL:   rdata <= {24'h0, ctrl_q};
                    OFS_STATUS: rdata <= {26'h0, ~s2_q[PIN_PRE_N], lamp_test_q,
                                          gate_open_q, state_q};
                    OFS_RESULT: rdata <= result_q;
                    default:    rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    a_abort_lamp: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && !s2_q[PIN_RST_N] |=> lamp_test_q && state_q == ST_ABORT)
        else $error("reset low did not abort with lamp test");
    a_abort_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && !s2_q[PIN_RST_N] |=> !gate_open_q)
        else $error("gate open during reset");
    a_resume_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && state_q == ST_ABORT && s2_q[PIN_RST_N] |=> state_q == ST_ARM)
        else $error("no fresh start after reset release");
    a_arm_blocks: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && state_q == ST_ARM && !arm_ok |=> state_q inside {ST_ARM, ST_ABORT})
        else $error("measurement started while disarmed");
    a_rear_arm_and: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && state_q == ST_ARM && ctrl_q[CTRL_REAR_BIT] && !s2_q[PIN_ARM_N]
        |=> state_q != ST_GATE && state_q != ST_SYNC)
        else $error("rear arm low ignored");
    a_wait_arm: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && $rose(state_q == ST_GATE) |-> $past(arm_ok, 1) || $past(a_edge, 1))
        else $error("gate opened without arming");
    a_prescale_up: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && state_q == ST_DONE && func == frequency_first_channel && !s2_q[PIN_PRE_N]
        |=> result_q == {$past(count_q[27:0]), 4'h0})
        else $error("frequency not scaled by sixteen");
    a_prescale_down: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && state_q == ST_DONE && func == period_first_channel && !s2_q[PIN_PRE_N]
        |=> result_q == {4'h0, $past(count_q[31:4])})
        else $error("period not scaled by sixteen");
    a_ref_toggle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && !ctrl_q[CTRL_EXT_BIT] |=> ref_out_q != $past(ref_out_q))
        else $error("internal timebase out stalled");
    a_ext_weight: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ctrl_q[CTRL_EXT_BIT] && std_sel == STD_1MHZ && unit_inc != 4'h0 |-> unit_inc == 4'hA)
        else $error("wrong weight for 1 MHz standard");
    a_idle_high: assert property (@(posedge ref_clk)
        !rst_n |=> s2_q[PIN_RST_N] && s2_q[PIN_ARM_N])
        else $error("reset or arm line not idle high");
    a_gate_track: assert property (@(posedge ref_clk) disable iff (!rst_n)
        gate_open_q == (state_q == ST_GATE))
        else $error("gate output out of step");
endmodule
`default_nettype wire

//--- rear_system_model.sv
`default_nettype none
module rear_system_model #(
    // minimum reset low time in clock cycles; default is about 10 ms at 100 ns
    parameter int unsigned RESET_HOLD = 100_000
) (
    input  wire logic       ref_clk,
    input  wire logic [7:0] a_div,
    input  wire logic [7:0] ext_div,
    input  wire logic       reset_req,
    input  wire logic       inhibit_req,
    input  wire logic       prescale_req,
    output logic            ext_ref,
    output logic            ch_a,
    output logic            ch_b,
    output logic            prescale_n,
    output logic            rear_reset_n,
    output logic            rear_arm_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] a_cnt = 8'h00;
    logic [7:0] e_cnt = 8'h00;
    int unsigned low_cnt = 0;
    initial ch_b = 1'b0;
    initial rear_reset_n = 1'b1;
    always @(posedge ref_clk) begin
        a_cnt <= (a_cnt + 8'h01 >= a_div) ? 8'h00 : a_cnt + 8'h01;
        e_cnt <= (e_cnt + 8'h01 >= ext_div) ? 8'h00 : e_cnt + 8'h01;
        ch_b  <= ~ch_b;
    end
    assign ch_a = (a_cnt < (a_div >> 1));
    assign ext_ref = (e_cnt < (ext_div >> 1));
    // reset idles high; once pulled low it stays low for RESET_HOLD cycles
    always @(posedge ref_clk) begin
        if (reset_req || (!rear_reset_n && low_cnt < RESET_HOLD)) begin
            rear_reset_n <= 1'b0;
            low_cnt      <= low_cnt + 1;
        end else begin
            rear_reset_n <= 1'b1;
            low_cnt      <= 0;
        end
    end
    // arm idles high, low only on request
    always @(posedge ref_clk) rear_arm_n <= ~inhibit_req;
    always @(posedge ref_clk) prescale_n <= ~prescale_req;
endmodule
`default_nettype wire

//--- tb_top.sv
`default_nettype none
module tb_top;
    import counter_rear_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic [31:0] result_q;
    logic [31:0] r;
    logic        ext_ref, ch_a, ch_b, prescale_n, rear_reset_n, rear_arm_n;
    logic        ref_out_q, gate_open_q, lamp_test_q, result_valid_q;
    logic [7:0]  a_div = 8'h28;
    logic [7:0]  ext_div = 8'h0A;
    logic        reset_req = 1'b0;
    logic        inhibit_req = 1'b0;
    logic        prescale_req = 1'b0;
    int          mismatches = 0;
    int          tests_run = 0;
    logic [7:0]  t_ctrl [7] = '{8'hC1, 8'hC1, 8'hC9, 8'hD9, 8'hE9, 8'hC2, 8'hC2};
    logic        t_pre [7] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    logic [7:0]  t_ext [7] = '{8'h0A, 8'h0A, 8'h0A, 8'h02, 8'h02, 8'h0A, 8'h0A};
    logic [31:0] t_exp [7] = '{32'h28, 32'h02, 32'h28, 32'h28, 32'h14, 32'h14, 32'h01};

    always #50 ref_clk = ~ref_clk;

    counter_rear_port_control #(.GATE_UNITS(20)) counter_rear_port_control_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .ext_ref(ext_ref), .ch_a(ch_a), .ch_b(ch_b),
        .prescale_n(prescale_n), .rear_reset_n(rear_reset_n), .rear_arm_n(rear_arm_n),
        .ref_out_q(ref_out_q), .gate_open_q(gate_open_q), .lamp_test_q(lamp_test_q),
        .result_q(result_q), .result_valid_q(result_valid_q));

    rear_system_model #(.RESET_HOLD(32)) rear_system_model_i (
        .ref_clk(ref_clk), .a_div(a_div), .ext_div(ext_div), .reset_req(reset_req),
        .inhibit_req(inhibit_req), .prescale_req(prescale_req), .ext_ref(ext_ref),
        .ch_a(ch_a), .ch_b(ch_b), .prescale_n(prescale_n),
        .rear_reset_n(rear_reset_n), .rear_arm_n(rear_arm_n));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // bounded wait for a result pulse; an absent pulse yields unknown data
    task automatic wait_valid(output logic [31:0] d);
        d = 'x;
        for (int i = 0; i < 600; i++) begin
            @(posedge ref_clk);
            #1;
            if (result_valid_q === 1'b1) begin
                d = result_q;
                break;
            end
        end
    endtask
    task automatic gate_closed(input int cycles, output logic seen);
        seen = 1'b0;
        repeat (cycles) begin
            @(posedge ref_clk);
            #1 seen = seen | (gate_open_q !== 1'b0);
        end
    endtask
    task automatic wait_gate(output logic seen);
        seen = 1'b0;
        for (int i = 0; i < 200 && !seen; i++) begin
            @(posedge ref_clk);
            #1 seen = (gate_open_q === 1'b1);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #(100 * 40000);
        mismatches++;
        test_done();
    end

    initial begin
        logic s;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_reg(OFS_CTRL, r);
        chk(r, {24'h0, CTRL_RESET});
        rd_reg(4'hC, r);
        chk(r, 32'h0);
        rd_reg(OFS_STATUS, r);
        chk({31'h0, r[STAT_LAMP_BIT]}, 32'h0);
        s = ref_out_q;
        @(posedge ref_clk);
        #1 chk({31'h0, ref_out_q}, {31'h0, ~s});
        $display("test idle done");
        for (int k = 0; k < 7; k++) begin
            prescale_req <= t_pre[k];
            ext_div <= t_ext[k];
            wr_reg(OFS_CTRL, {24'h0, t_ctrl[k]});
            wait_valid(r);
            wait_valid(r);
            chk(r, t_exp[k]);
        end
        $display("test timebase done");
        prescale_req <= 1'b1;
        a_div <= 8'h04;
        wr_reg(OFS_CTRL, 32'hC0);
        wait_valid(r);
        wait_valid(r);
        chk(r & 32'hF, 32'h0);
        chk({31'h0, r != 32'h0}, 32'h1);
        prescale_req <= 1'b0;
        wr_reg(OFS_CTRL, 32'hC3);
        repeat (60) @(posedge ref_clk);
        inhibit_req <= 1'b1;
        wait_valid(r);
        chk({31'h0, r != 32'h0}, 32'h1);
        gate_closed(30, s);
        chk({31'h0, s}, 32'h0);
        inhibit_req <= 1'b0;
        wr_reg(OFS_CTRL, 32'h43);
        gate_closed(30, s);
        chk({31'h0, s}, 32'h0);
        inhibit_req <= 1'b1;
        wr_reg(OFS_CTRL, 32'h83);
        wait_gate(s);
        chk({31'h0, s}, 32'h1);
        inhibit_req <= 1'b0;
        $display("test arming done");
        a_div <= 8'h28;
        wr_reg(OFS_CTRL, 32'hC1);
        wait_gate(s);
        reset_req <= 1'b1;
        inhibit_req <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 chk({31'h0, lamp_test_q}, 32'h1);
        chk({31'h0, gate_open_q}, 32'h0);
        rd_reg(OFS_STATUS, r);
        chk({31'h0, r[STAT_LAMP_BIT]}, 32'h1);
        // reset request outlasts the scaled minimum hold of the model
        repeat (30) @(posedge ref_clk);
        reset_req <= 1'b0;
        repeat (5) @(posedge ref_clk);
        #1 chk({31'h0, lamp_test_q}, 32'h0);
        gate_closed(30, s);
        chk({31'h0, s}, 32'h0);
        inhibit_req <= 1'b0;
        wait_valid(r);
        chk(r, 32'h28);
        $display("test rear reset done");
        test_done();
    end
endmodule
`default_nettype wire
